// ==== rtl/hrla_device.sv ====
// How it works
// - Command bits 23-21: 000 write, 001 read
// - Bit 20 picks memory or registers
// - Memory access uses bits 19-0 as address
// - Register byte enable bit set blocks that byte
// - Register address bits 10-0; 15-11 ignored
// - Command arrives high byte first, three bytes
// - Data word follows, four bytes, low first
// - Register space: eight blocks of 256 bytes
// - Top digit selects block: 0,2,3,5 modules
// - Software writes zero to reserved bits
// - Internal enable routes internal interrupt to PCI
// - External enable routes shared input to PCI
// - Field 15-13 selects one ISA line
// - At most one ISA line asserted
// - Select decode: none,A,B,C,D(10x),E(11x)
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "hrla_consts.svh"
module hrla_device
    import hrla_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link to the controller
    hrla_link_if.dev link,
    // Access port to memory and module registers
    output logic acc_req,
    output logic acc_we,
    output logic acc_is_reg,
    output logic [19:0] acc_addr,
    output logic [3:0] acc_be,
    output logic [31:0] acc_wdata,
    input wire logic [31:0] acc_rdata,
    input wire logic acc_ack,
    // Host-link control value for other modules
    output logic [31:0] link_ctrl,
    // Interrupts
    input wire logic internal_irq,
    input wire logic shared_interrupt_in_n,
    output logic pci_irq_n,
    output logic [4:0] isa_irq_n
);

    hrla_dev_state_t state_r;
    logic [23:0] cmd_r;
    logic [31:0] data_r;
    logic [31:0] rsp_r;
    logic [2:0] cnt_r;
    logic [31:0] ctrl_r;
    logic ready_r;
    logic d2h_valid_r;
    logic [7:0] d2h_byte_r;

    logic [23:0] cmd_full;
    logic [2:0] op;
    logic is_write;
    logic is_read;
    logic [2:0] blk;
    logic [7:0] idx;
    logic [3:0] be_on;
    hrla_target_t target;
    logic local_we;
    logic [31:0] local_rd;
    logic [31:0] be_mask;

    localparam logic [31:0] CTRL_RST = `HRLA_CTRL_RESET;
    localparam logic [31:0] CTRL_WMASK = `HRLA_CTRL_WMASK;

    // Shift in the next command byte, high byte first
    assign cmd_full = {cmd_r[15:0], link.h2d_byte};
    assign op = cmd_r[`HRLA_OP_HI:`HRLA_OP_LO];
    assign is_write = (op == `HRLA_OP_WRITE);
    assign is_read = (op == `HRLA_OP_READ);
    // Bits 15-11 never enter the decode
    assign blk = cmd_r[`HRLA_BLK_HI:`HRLA_BLK_LO];
    assign idx = cmd_r[7:0];
    // Byte enables in the command are active high disables
    assign be_on = ~cmd_r[`HRLA_BE_LO+3:`HRLA_BE_LO];

    always_comb begin
        if (!cmd_r[`HRLA_TGT_BIT]) begin
            target = TGT_USER;
        end else begin
            case (blk)
                `HRLA_BLK_HOSTLINK: target = TGT_LOCAL;
                `HRLA_BLK_MEMIF, `HRLA_BLK_AUDIO, `HRLA_BLK_VIDEO: target = TGT_USER;
                default: target = TGT_NONE;
            endcase
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_mask
        assign be_mask[8*b+:8] = {8{be_on[b]}};
    end

    // Local block: identification and control
    always_comb begin
        case (idx)
            `HRLA_IDX_ID: local_rd = {16'h0000, REVISION, DEVICE_ID};
            `HRLA_IDX_CTRL: local_rd = ctrl_r;
            default: local_rd = 32'h00000000;
        endcase
    end

    assign local_we = (state_r == DEV_EXEC) && is_write && cmd_r[`HRLA_TGT_BIT] &&
        (target == TGT_LOCAL) && (idx == `HRLA_IDX_CTRL);

    // Reserved bits keep their fixed values whatever software writes
    for (genvar b = 0; b < 4; b++) begin : g_ctrl
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctrl_r[8*b+:8] <= CTRL_RST[8*b+:8];
            end else if (local_we && be_on[b]) begin
                ctrl_r[8*b+:8] <= (data_r[8*b+:8] & CTRL_WMASK[8*b+:8]) |
                    (ctrl_r[8*b+:8] & ~CTRL_WMASK[8*b+:8]);
            end
        end
    end

    // Transfer sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= DEV_CMD;
            cmd_r <= 24'h000000;
            data_r <= 32'h00000000;
            rsp_r <= 32'h00000000;
            cnt_r <= 3'h0;
        end else begin
            case (state_r)
                DEV_CMD: begin
                    if (link.h2d_valid) begin
                        cmd_r <= cmd_full;
                        if (cnt_r == `HRLA_CMD_BYTES - 3'h1) begin
                            cnt_r <= 3'h0;
                            // Unknown command codes are dropped, no data follows them
                            if (cmd_full[`HRLA_OP_HI:`HRLA_OP_LO] == `HRLA_OP_WRITE) begin
                                state_r <= DEV_WDATA;
                            end else if (cmd_full[`HRLA_OP_HI:`HRLA_OP_LO] == `HRLA_OP_READ) begin
                                state_r <= DEV_EXEC;
                            end
                        end else begin
                            cnt_r <= cnt_r + 3'h1;
                        end
                    end
                end
                DEV_WDATA: begin
                    if (link.h2d_valid) begin
                        data_r <= {link.h2d_byte, data_r[31:8]};
                        if (cnt_r == `HRLA_DATA_BYTES - 3'h1) begin
                            cnt_r <= 3'h0;
                            state_r <= DEV_EXEC;
                        end else begin
                            cnt_r <= cnt_r + 3'h1;
                        end
                    end
                end
                DEV_EXEC: begin
                    if (target == TGT_USER) begin
                        state_r <= DEV_WAIT;
                    end else begin
                        // Disabled bytes read back as zero
                        rsp_r <= (target == TGT_LOCAL) ? (local_rd & be_mask) : 32'h00000000;
                        state_r <= is_read ? DEV_RESP : DEV_CMD;
                    end
                end
                DEV_WAIT: begin
                    if (acc_ack) begin
                        rsp_r <= acc_rdata & (cmd_r[`HRLA_TGT_BIT] ? be_mask : 32'hFFFFFFFF);
                        state_r <= is_read ? DEV_RESP : DEV_CMD;
                    end
                end
                DEV_RESP: begin
                    rsp_r <= {8'h00, rsp_r[31:8]};
                    if (cnt_r == `HRLA_DATA_BYTES - 3'h1) begin
                        cnt_r <= 3'h0;
                        state_r <= DEV_CMD;
                    end else begin
                        cnt_r <= cnt_r + 3'h1;
                    end
                end
                default: begin
                    state_r <= DEV_CMD;
                    cnt_r <= 3'h0;
                end
            endcase
        end
    end

    // Answer bytes, low byte first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d2h_valid_r <= 1'b0;
            d2h_byte_r <= 8'h00;
        end else begin
            d2h_valid_r <= (state_r == DEV_RESP);
            d2h_byte_r <= (state_r == DEV_RESP) ? rsp_r[7:0] : 8'h00;
        end
    end

    // Ready lags the state by one edge; a controller start right after a write frame still sees it high in the cycle after the last byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= (state_r == DEV_CMD) || (state_r == DEV_WDATA);
        end
    end

    // User access port, request held until acknowledged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_req <= 1'b0;
            acc_we <= 1'b0;
            acc_is_reg <= 1'b0;
            acc_addr <= 20'h00000;
            acc_be <= 4'h0;
            acc_wdata <= 32'h00000000;
        end else if (state_r == DEV_EXEC && target == TGT_USER) begin
            acc_req <= 1'b1;
            acc_we <= is_write;
            acc_is_reg <= cmd_r[`HRLA_TGT_BIT];
            if (cmd_r[`HRLA_TGT_BIT]) begin
                acc_addr <= {9'h000, cmd_r[`HRLA_RADDR_HI:0]};
                acc_be <= be_on;
            end else begin
                acc_addr <= cmd_r[`HRLA_MADDR_HI:0];
                acc_be <= 4'hF;
            end
            acc_wdata <= data_r;
        end else if (state_r == DEV_WAIT && acc_ack) begin
            acc_req <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_ctrl <= `HRLA_CTRL_RESET;
        end else begin
            link_ctrl <= ctrl_r;
        end
    end

    assign link.d2h_ready = ready_r;
    assign link.d2h_valid = d2h_valid_r;
    assign link.d2h_byte = d2h_byte_r;

    hrla_irq_route #(
        .ISA_LINES(5)
    ) u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .internal_irq(internal_irq),
        .shared_interrupt_in_n(shared_interrupt_in_n),
        .pci_internal_irq_enable(ctrl_r[`HRLA_PCI_INTERNAL_IRQ_ENABLE_BIT]),
        .pci_external_irq_enable(ctrl_r[`HRLA_PCI_EXTERNAL_IRQ_ENABLE_BIT]),
        .isa_irq_select(ctrl_r[`HRLA_ISA_HI:`HRLA_ISA_LO]),
        .pci_irq_n(pci_irq_n),
        .isa_irq_n(isa_irq_n)
    );

endmodule : hrla_device

// ==== rtl/hrla_consts.svh ====
`ifndef HRLA_CONSTS_SVH
`define HRLA_CONSTS_SVH

// Command word layout
`define HRLA_OP_HI 23
`define HRLA_OP_LO 21
`define HRLA_OP_WRITE 3'h0
`define HRLA_OP_READ 3'h1
`define HRLA_TGT_BIT 20
`define HRLA_MADDR_HI 19
`define HRLA_BE_LO 16
`define HRLA_RADDR_HI 10
`define HRLA_BLK_HI 10
`define HRLA_BLK_LO 8

// Link framing
`define HRLA_CMD_BYTES 3'h3
`define HRLA_DATA_BYTES 3'h4

// Register blocks
`define HRLA_BLK_HOSTLINK 3'h0
`define HRLA_BLK_MEMIF 3'h2
`define HRLA_BLK_AUDIO 3'h3
`define HRLA_BLK_VIDEO 3'h5

// Host-link block registers
`define HRLA_IDX_ID 8'h00
`define HRLA_IDX_CTRL 8'h20
`define HRLA_CTRL_RESET 32'h000107C8
`define HRLA_CTRL_WMASK 32'h0000FFC1
`define HRLA_PCI_INTERNAL_IRQ_ENABLE_BIT 11
`define HRLA_PCI_EXTERNAL_IRQ_ENABLE_BIT 12
`define HRLA_ISA_HI 15
`define HRLA_ISA_LO 13

// Controller registers on the AHB side
`define HRLA_H_CMD 4'h0
`define HRLA_H_WDATA 4'h4
`define HRLA_H_RDATA 4'h8
`define HRLA_H_STAT 4'hC
`define HRLA_STAT_BUSY 0
`define HRLA_STAT_DONE 1

`endif

// ==== rtl/hrla_pkg.sv ====
package hrla_pkg;

    typedef enum logic [2:0] {DEV_CMD, DEV_WDATA, DEV_EXEC, DEV_WAIT, DEV_RESP} hrla_dev_state_t;

    typedef enum logic [1:0] {HOST_IDLE, HOST_SEND, HOST_RECV} hrla_host_state_t;

    typedef enum logic [1:0] {TGT_LOCAL, TGT_USER, TGT_NONE} hrla_target_t;

endpackage : hrla_pkg

// ==== rtl/hrla_link_if.sv ====
`timescale 1ns/100ps
interface hrla_link_if;
    // Host to device bytes
    logic h2d_valid;
    logic [7:0] h2d_byte;
    // Device to host
    logic d2h_ready;
    logic d2h_valid;
    logic [7:0] d2h_byte;

    modport dev (input h2d_valid, input h2d_byte, output d2h_ready, output d2h_valid, output d2h_byte);
    modport host (output h2d_valid, output h2d_byte, input d2h_ready, input d2h_valid, input d2h_byte);
endinterface : hrla_link_if

// ==== rtl/hrla_irq_route.sv ====
`timescale 1ns/100ps
`include "hrla_consts.svh"
module hrla_irq_route
    import hrla_pkg::*;
#(
    parameter int ISA_LINES = 5
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Sources and enables
    input wire logic internal_irq,
    input wire logic shared_interrupt_in_n,
    input wire logic pci_internal_irq_enable,
    input wire logic pci_external_irq_enable,
    input wire logic [2:0] isa_irq_select,
    // Pins, active low
    output logic pci_irq_n,
    output logic [ISA_LINES-1:0] isa_irq_n
);

    initial begin
        if (ISA_LINES != 5) $error("hrla_irq_route: the select field serves exactly five lines");
    end

    logic [ISA_LINES-1:0] isa_onehot;

    always_comb begin
        isa_onehot = '0;
        case (isa_irq_select)
            3'h0: isa_onehot = '0;
            3'h1: isa_onehot[0] = 1'b1;
            3'h2: isa_onehot[1] = 1'b1;
            3'h3: isa_onehot[2] = 1'b1;
            3'h4, 3'h5: isa_onehot[3] = 1'b1;
            3'h6, 3'h7: isa_onehot[4] = 1'b1;
            default: isa_onehot = '0;
        endcase
    end

    // Level outputs follow the sources; one-hot decode keeps lines exclusive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pci_irq_n <= 1'b1;
        end else begin
            pci_irq_n <= !((internal_irq && pci_internal_irq_enable) ||
                (!shared_interrupt_in_n && pci_external_irq_enable));
        end
    end

    for (genvar i = 0; i < ISA_LINES; i++) begin : g_isa
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                isa_irq_n[i] <= 1'b1;
            end else begin
                isa_irq_n[i] <= !(internal_irq && isa_onehot[i]);
            end
        end
    end

endmodule : hrla_irq_route

// ==== rtl/hrla_host.sv ====
`timescale 1ns/100ps
`include "hrla_consts.svh"
module hrla_host
    import hrla_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Link to the device
    hrla_link_if.host link
);

    hrla_host_state_t state_r;
    logic [23:0] cmd_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic [55:0] shift_r;
    logic [2:0] left_r;
    logic [2:0] rcnt_r;
    logic busy_r;
    logic done_r;
    logic wr_pend_r;
    logic [3:0] waddr_r;
    logic h2d_valid_r;
    logic [7:0] h2d_byte_r;
    logic [31:0] rd_mux;
    logic start;
    logic finish;
    logic done_clr;
    logic is_write_cmd;

    // Registers answer with no wait state
    always_comb begin
        case (haddr[3:0])
            `HRLA_H_CMD: rd_mux = {8'h00, cmd_r};
            `HRLA_H_WDATA: rd_mux = wdata_r;
            `HRLA_H_RDATA: rd_mux = rdata_r;
            `HRLA_H_STAT: rd_mux = {30'h00000000, done_r, busy_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            waddr_r <= 4'h0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_r <= hsel && hready && htrans[1] && hwrite;
            waddr_r <= haddr[3:0];
            if (hsel && hready && htrans[1] && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // A data write starts the transfer, as in the relaying accelerator
    assign start = wr_pend_r && (waddr_r == `HRLA_H_WDATA) && !busy_r;
    assign done_clr = wr_pend_r && (waddr_r == `HRLA_H_STAT) && hwdata[`HRLA_STAT_DONE];
    assign is_write_cmd = (cmd_r[`HRLA_OP_HI:`HRLA_OP_LO] == `HRLA_OP_WRITE);
    assign finish = ((state_r == HOST_SEND) && link.d2h_ready && (left_r == 3'h1) && is_write_cmd) ||
        ((state_r == HOST_RECV) && link.d2h_valid && (rcnt_r == `HRLA_DATA_BYTES - 3'h1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_r <= 24'h000000;
            wdata_r <= 32'h00000000;
        end else if (wr_pend_r && !busy_r) begin
            if (waddr_r == `HRLA_H_CMD) begin
                cmd_r <= hwdata[23:0];
            end
            if (waddr_r == `HRLA_H_WDATA) begin
                wdata_r <= hwdata;
            end
        end
    end

    // Done is sticky; a finish in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r <= 1'b0;
        end else if (finish) begin
            done_r <= 1'b1;
        end else if (done_clr || start) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= HOST_IDLE;
            busy_r <= 1'b0;
            shift_r <= 56'h0;
            left_r <= 3'h0;
            rcnt_r <= 3'h0;
            rdata_r <= 32'h00000000;
            h2d_valid_r <= 1'b0;
            h2d_byte_r <= 8'h00;
        end else begin
            h2d_valid_r <= 1'b0;
            case (state_r)
                HOST_IDLE: begin
                    if (start) begin
                        busy_r <= 1'b1;
                        // Command high byte first, then data low byte first
                        shift_r <= {cmd_r[23:16], cmd_r[15:8], cmd_r[7:0],
                            hwdata[7:0], hwdata[15:8], hwdata[23:16], hwdata[31:24]};
                        left_r <= is_write_cmd ? `HRLA_CMD_BYTES + `HRLA_DATA_BYTES : `HRLA_CMD_BYTES;
                        state_r <= HOST_SEND;
                    end
                end
                HOST_SEND: begin
                    if (link.d2h_ready) begin
                        h2d_valid_r <= 1'b1;
                        h2d_byte_r <= shift_r[55:48];
                        shift_r <= {shift_r[47:0], 8'h00};
                        left_r <= left_r - 3'h1;
                        if (left_r == 3'h1) begin
                            rcnt_r <= 3'h0;
                            state_r <= is_write_cmd ? HOST_IDLE : HOST_RECV;
                            busy_r <= !is_write_cmd;
                        end
                    end
                end
                HOST_RECV: begin
                    if (link.d2h_valid) begin
                        rdata_r <= {link.d2h_byte, rdata_r[31:8]};
                        rcnt_r <= rcnt_r + 3'h1;
                        if (rcnt_r == `HRLA_DATA_BYTES - 3'h1) begin
                            busy_r <= 1'b0;
                            state_r <= HOST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= HOST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    assign link.h2d_valid = h2d_valid_r;
    assign link.h2d_byte = h2d_byte_r;

endmodule : hrla_host

// ==== verif/hrla_link_chk.sv ====
`timescale 1ns/100ps
module hrla_link_chk (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link wires
    input wire logic h2d_valid,
    input wire logic [7:0] h2d_byte,
    input wire logic d2h_ready,
    input wire logic d2h_valid,
    input wire logic [7:0] d2h_byte
);
    logic [2:0] idx_r;
    logic wr_r, owed_r, is_wr, rd_end, wr_end;
    assign is_wr = (idx_r == 3'h0) ? (h2d_byte[7:5] == 3'h0) : wr_r;
    assign rd_end = h2d_valid && idx_r == 3'h2 && !is_wr;
    assign wr_end = h2d_valid && idx_r == 3'h6;
    // Byte position in frame; only legal commands expected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_r <= 3'h0;
            wr_r <= 1'b0;
        end else if (h2d_valid) begin
            wr_r <= is_wr;
            idx_r <= (rd_end || wr_end) ? 3'h0 : idx_r + 3'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            owed_r <= 1'b0;
        end else begin
            owed_r <= rd_end ? 1'b1 : (d2h_valid ? 1'b0 : owed_r);
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_send_when_ready: assert property (h2d_valid |-> d2h_ready)
        else $error("byte sent while device not accepting");
    chk_resp_four: assert property ($rose(d2h_valid) |-> d2h_valid [*4] ##1 !d2h_valid)
        else $error("read answer is not four bytes");
    chk_write_run: assert property (h2d_valid && idx_r == 3'h0 && is_wr |=> h2d_valid [*6])
        else $error("write frame not seven bytes");
    chk_read_answer: assert property (rd_end |-> ##[1:80] d2h_valid)
        else $error("read command got no answer");
    chk_read_quiet: assert property (rd_end |-> ##2 !d2h_ready)
        else $error("device still accepting after read command");
    chk_write_silent: assert property (wr_end |=> !d2h_valid [*4])
        else $error("write answered with data");
    chk_resp_owed: assert property ($rose(d2h_valid) |-> owed_r)
        else $error("answer without read command");
    chk_ready_back: assert property ($fell(d2h_valid) |-> ##[0:3] d2h_ready)
        else $error("device not ready after answer");
    cov_read: cover property (rd_end ##[1:80] $fell(d2h_valid));
    cov_write: cover property (wr_end);
    cov_back: cover property (wr_end ##[1:40] h2d_valid);
endmodule : hrla_link_chk

// ==== verif/host_register_access_irq_tb.sv ====
`timescale 1ns/100ps
`include "hrla_consts.svh"
module host_register_access_irq_tb;
    import hrla_pkg::*;
    // Arbitrary identity values
    localparam logic [7:0] ID_V = 8'h3B;
    localparam logic [7:0] REV_V = 8'h02;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic internal_irq = 1'b0;
    logic shared_interrupt_in_n = 1'b1;
    logic acc_ack = 1'b0;
    logic [31:0] acc_rdata = 32'h0;
    logic [31:0] ans = 32'h0;
    logic hreadyout, hresp, acc_req, acc_we, acc_is_reg, pci_irq_n;
    logic [31:0] hrdata, acc_wdata, link_ctrl;
    logic [19:0] acc_addr;
    logic [3:0] acc_be;
    logic [4:0] isa_irq_n;
    logic [57:0] acc_log;
    int acc_n = 0;
    int fail_count = 0;
    int checks_done = 0;
    always #2.5 hclk = ~hclk;
    hrla_link_if link_bus ();
    hrla_host i_hrla_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .link(link_bus.host));
    hrla_device #(.DEVICE_ID(ID_V), .REVISION(REV_V)) i_hrla_device (.hclk(hclk), .hresetn(hresetn),
        .link(link_bus.dev), .acc_req(acc_req), .acc_we(acc_we), .acc_is_reg(acc_is_reg), .acc_addr(acc_addr),
        .acc_be(acc_be), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .link_ctrl(link_ctrl),
        .internal_irq(internal_irq), .shared_interrupt_in_n(shared_interrupt_in_n), .pci_irq_n(pci_irq_n),
        .isa_irq_n(isa_irq_n));
    hrla_link_chk i_hrla_link_chk (.hclk(hclk), .hresetn(hresetn), .h2d_valid(link_bus.h2d_valid),
        .h2d_byte(link_bus.h2d_byte), .d2h_ready(link_bus.d2h_ready), .d2h_valid(link_bus.d2h_valid),
        .d2h_byte(link_bus.d2h_byte));
    // Access port far side; random stalls, data scrambled when idle
    always @(posedge hclk) begin
        if (acc_req === 1'b1 && acc_ack !== 1'b1 && $urandom_range(1, 0) == 1) begin
            acc_ack <= 1'b1;
            acc_rdata <= ans;
            acc_log <= {acc_we, acc_is_reg, acc_addr, acc_be, acc_wdata};
            acc_n <= acc_n + 1;
        end else begin
            acc_ack <= 1'b0;
            acc_rdata <= ~acc_rdata;
        end
    end
    function automatic logic [31:0] bm(input logic [3:0] en);
        bm = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
    endfunction : bm
    task cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task stop_test;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task hang;
        fail_count++;
        $display("ERROR wait expected done seen timeout");
        stop_test();
    endtask : hang
    task wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) hang();
            @(posedge hclk);
        end
    endtask : wait_rdy
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask : ahb
    // Read needs the data write too, it starts the transfer
    task xfer(input logic [23:0] c, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        ahb(1'b1, 8'h00, {8'h0, c}, r);
        ahb(1'b1, 8'h04, d, r);
        do begin
            ahb(1'b0, 8'h0C, 32'h0, r);
            n++;
            if (n > 100) hang();
        end while (r[1] !== 1'b1);
        ahb(1'b1, 8'h0C, 32'h2, r);
        ahb(1'b0, 8'h08, 32'h0, r);
        // After a write the host is done before the device has acted; wait for it to take bytes again
        n = 0;
        while (link_bus.d2h_ready !== 1'b1) begin
            n++;
            if (n > 100) hang();
            @(posedge hclk);
        end
    endtask : xfer
    initial begin
        logic [31:0] r, d, upd, ctrl_m;
        logic [23:0] c;
        logic [4:0] isa;
        logic [2:0] s;
        logic user, wr;
        int n0;
        r = $urandom(6);
        ctrl_m = `HRLA_CTRL_RESET;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        cmp("ctrl_reset", ctrl_m, link_ctrl);
        for (int k = 0; k < 4; k++) begin
            c = {3'h1, 1'b1, 4'($urandom), 5'($urandom), 11'h000};
            n0 = acc_n;
            xfer(c, 32'h0, r);
            cmp("ident", {16'h0, REV_V, ID_V} & bm(~c[19:16]), r);
            cmp("ident_local", n0, acc_n);
        end
        // Byte 1 always enabled so every select code is reached
        for (int k = 0; k < 8; k++) begin
            c = {3'h0, 1'b1, 4'($urandom) & 4'hD, 5'($urandom), 11'h020};
            d = {16'h0, 3'(k), 13'($urandom)} & `HRLA_CTRL_WMASK;
            upd = `HRLA_CTRL_WMASK & bm(~c[19:16]);
            ctrl_m = (ctrl_m & ~upd) | (d & upd);
            xfer(c, d, r);
            cmp("ctrl", ctrl_m, link_ctrl);
            xfer({3'h1, 1'b1, 9'h0, 11'h020}, 32'h0, r);
            cmp("ctrl_read", ctrl_m, r);
            for (int j = 0; j < 4; j++) begin
                internal_irq <= j[0];
                shared_interrupt_in_n <= j[1];
                repeat (2) @(posedge hclk);
                s = ctrl_m[15:13];
                isa = 5'h1F;
                if (j[0] && s != 3'h0) isa[s[2] ? 3 + s[1] : s - 1] = 1'b0;
                cmp("irq", {!((j[0] && ctrl_m[11]) || (!j[1] && ctrl_m[12])), isa},
                    {pci_irq_n, isa_irq_n});
            end
        end
        for (int k = 0; k < 16; k++) begin
            c = 24'($urandom);
            c[23:22] = 2'h0;
            if (c[10:8] == 3'h0) c[8] = 1'b1;
            wr = !c[21];
            user = !c[20] || c[10:8] inside {3'h2, 3'h3, 3'h5};
            ans = $urandom;
            d = $urandom;
            n0 = acc_n;
            xfer(c, d, r);
            cmp("acc_count", n0 + user, acc_n);
            if (user) cmp("acc", {wr, c[20], c[20] ? {9'h0, c[10:0]} : c[19:0], c[20] ? ~c[19:16] : 4'hF},
                acc_log[57:32]);
            if (user && wr) cmp("acc_wdata", d, acc_log[31:0]);
            if (!wr) cmp("rdata", user ? (c[20] ? ans & bm(~c[19:16]) : ans) : 32'h0, r);
        end
        ahb(1'b1, 8'h10, 32'hFFFFFFFF, r);
        ahb(1'b0, 8'h10, 32'h0, r);
        // Four address bits decoded, so this offset aliases the command word
        cmp("cmd_alias", 32'h00FFFFFF, r);
        ahb(1'b0, 8'h0C, 32'h0, r);
        cmp("status", 32'h0, r);
        stop_test();
    end
endmodule : host_register_access_irq_tb
